// file: rtl/srr_top.sv
// serial reading responder: sends the five display digits on request
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module srr_top
#(
   parameter longint CLK_HZ = srr_pkg::CLK_HZ
)
(
   input  wire logic                         core_clk,
   input  wire logic                         rst_b,
   input  wire logic                         rx_line,
   output logic                              tx_line,
   input  wire logic                         foot_closed,
   input  wire srr_pkg::srr_digits_t         digits,
   input  wire logic [srr_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [srr_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic [srr_pkg::DATA_W-1:0]        reg_rdata,
   output logic                              busy
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic                           rst_meta_q;
   logic                           rst_n;

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   srr_pkg::srr_ctrl_t             ctrl_q;
   srr_pkg::srr_ctrl_t             frame_q;
   srr_pkg::srr_digits_t           snap_q;
   srr_pkg::srr_tx_st_t            st_q;
   srr_pkg::srr_tx_st_t            st_d;
   srr_pkg::srr_stat_t             stat;
   logic [srr_pkg::DIV_W-1:0]      div_q;
   logic [srr_pkg::DIV_W-1:0]      cnt_q;
   logic [srr_pkg::DIV_W-1:0]      cnt_d;
   logic [2:0]                     char_q;
   logic [2:0]                     char_d;
   logic [2:0]                     bit_q;
   logic [2:0]                     bit_d;
   logic [7:0]                     shf_q;
   logic [7:0]                     shf_d;
   logic                           tx_d;
   logic [srr_pkg::CNT_W-1:0]      count_q;
   logic                           foot_q;
   logic                           ctrl_wr_seen_q;
   logic                           rx_done;
   logic                           foot_rise;
   logic                           trig;
   logic                           start;
   logic                           tick;
   logic                           last_bit;
   logic                           last_char;
   logic                           reading_end;
   logic [7:0]                     char_code;
   logic [3:0]                     cur_digit;
   logic [srr_pkg::DATA_W-1:0]     rd_mux;
   logic                           wr_ctrl;

   // ----------------------------------------------------------------
   // receiver
   // ----------------------------------------------------------------
   // receive line only, no handshake
   srr_rx u_rx
   (
      .clk     (core_clk),
      .rst_n   (rst_n),
      .rx_line (rx_line),
      .div     (div_q),
      .word8   (ctrl_q.word8),
      .done    (rx_done)
   );

   // ----------------------------------------------------------------
   // trigger selection
   // ----------------------------------------------------------------
   // foot switch is taken as clean; bounce while busy is dropped anyway
   assign foot_rise = foot_closed & ~foot_q;
   // internal or external source
   // pick the trigger
   assign trig      = ctrl_q.ext_mode ? foot_rise : rx_done;
   // half duplex: a character heard while sending starts nothing
   // busy masks requests
   assign start     = trig & (st_q == srr_pkg::TX_IDLE);

   // ----------------------------------------------------------------
   // transmit sequencing
   // ----------------------------------------------------------------
   assign tick        = (cnt_q == '0);
   // data bit count from word length
   assign last_bit    = (bit_q == (frame_q.word8 ? srr_pkg::LAST_BIT8 : srr_pkg::LAST_BIT7));
   assign last_char   = (char_q == srr_pkg::LAST_CHAR);
   assign reading_end = (st_q == srr_pkg::TX_STOP) & tick & last_char;
   assign cur_digit   = snap_q[3'(srr_pkg::LAST_CHAR - char_q)];
   assign char_code   = srr_pkg::ASCII_ZERO + {4'h0, cur_digit};

   always_comb
   begin
      st_d   = st_q;
      cnt_d  = tick ? div_q - 1'b1 : cnt_q - 1'b1;
      char_d = char_q;
      bit_d  = bit_q;
      shf_d  = shf_q;
      tx_d   = tx_line;
      unique case (st_q)
         srr_pkg::TX_IDLE:
         begin
            cnt_d  = div_q - 1'b1;
            char_d = '0;
            tx_d   = 1'b1;
            if (start)
               st_d = srr_pkg::TX_LOAD;
         end
         srr_pkg::TX_LOAD:
         begin
            cnt_d = div_q - 1'b1;
            shf_d = char_code;
            tx_d  = 1'b0;
            st_d  = srr_pkg::TX_START;
         end
         srr_pkg::TX_START:
            if (tick)
            begin
               tx_d  = shf_q[0];
               shf_d = shf_q >> 1;
               bit_d = '0;
               st_d  = srr_pkg::TX_DATA;
            end
         srr_pkg::TX_DATA:
            if (tick)
            begin
               // no parity slot after the data
               if (last_bit)
               begin
                  tx_d = 1'b1;
                  st_d = srr_pkg::TX_STOP;
               end
               else
               begin
                  tx_d  = shf_q[0];
                  shf_d = shf_q >> 1;
                  bit_d = bit_q + 1'b1;
               end
            end
         srr_pkg::TX_STOP:
            // one stop bit, then next digit, or idle after the fifth
            if (tick)
            begin
               if (last_char)
                  st_d = srr_pkg::TX_IDLE;
               else
               begin
                  char_d = char_q + 1'b1;
                  st_d   = srr_pkg::TX_LOAD;
               end
            end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q    <= srr_pkg::TX_IDLE;
         cnt_q   <= '0;
         char_q  <= '0;
         bit_q   <= '0;
         shf_q   <= '0;
         tx_line <= 1'b1;
         busy    <= 1'b0;
      end
      else
      begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         char_q  <= char_d;
         bit_q   <= bit_d;
         shf_q   <= shf_d;
         tx_line <= tx_d;
         busy    <= (st_d != srr_pkg::TX_IDLE);
      end
   end

   // reading and frame format are frozen for the whole reading
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         snap_q  <= '0;
         frame_q <= srr_pkg::CTRL_RST;
      end
      else if (start)
      begin
         snap_q  <= digits;
         frame_q <= ctrl_q;
      end
   end

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   assign wr_ctrl = reg_wr & (reg_addr == srr_pkg::A_CTRL);
   assign stat    = '{readings: count_q, foot: foot_closed, rx_level: rx_line, busy: busy};
   assign rd_mux  = (reg_addr == srr_pkg::A_CTRL) ? srr_pkg::DATA_W'(ctrl_q) :
                    (reg_addr == srr_pkg::A_STAT) ? srr_pkg::DATA_W'(stat) :
                    (reg_addr == srr_pkg::A_READ) ? srr_pkg::DATA_W'(snap_q) : '0;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q         <= srr_pkg::CTRL_RST;
         ctrl_wr_seen_q <= 1'b0;
         reg_rdata      <= '0;
         div_q          <= '0;
         foot_q         <= 1'b0;
         count_q        <= '0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            ctrl_q         <= reg_wdata[$bits(srr_pkg::srr_ctrl_t)-1:0];
            ctrl_wr_seen_q <= 1'b1;
         end
         reg_rdata <= reg_rd ? rd_mux : '0;
         div_q     <= srr_pkg::baud_div(ctrl_q.baud_code, CLK_HZ);
         foot_q    <= foot_closed;
         if (reading_end)
            count_q <= count_q + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_char_end;
      (st_q == srr_pkg::TX_STOP) && tick;
   endsequence

   sequence s_last_end;
      s_char_end and last_char;
   endsequence

   property p_baud_table;
      @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> div_q == srr_pkg::baud_div($past(ctrl_q.baud_code), CLK_HZ);
   endproperty
   a_baud_table: assert property (p_baud_table) else $error("divisor does not follow code");

   property p_baud_default;
      @(posedge core_clk) disable iff (!rst_n)
      reg_rd && reg_addr == srr_pkg::A_CTRL && !ctrl_wr_seen_q |=> reg_rdata[3:0] == srr_pkg::BAUD_DEF;
   endproperty
   a_baud_default: assert property (p_baud_default) else $error("baud code not default");

   property p_word_default;
      @(posedge core_clk) disable iff (!rst_n)
      !ctrl_wr_seen_q |-> !ctrl_q.word8;
   endproperty
   a_word_default: assert property (p_word_default) else $error("word length not seven");

   property p_stop_high;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(st_q == srr_pkg::TX_STOP) |-> tx_line ##1 tx_line;
   endproperty
   a_stop_high: assert property (p_stop_high) else $error("stop bit not high");

   property p_no_parity;
      @(posedge core_clk) disable iff (!rst_n)
      st_q == srr_pkg::TX_DATA && tick && last_bit |=> st_q == srr_pkg::TX_STOP;
   endproperty
   a_no_parity: assert property (p_no_parity) else $error("extra bit after data");

   property p_int_trig;
      @(posedge core_clk) disable iff (!rst_n)
      !ctrl_q.ext_mode && rx_done && !busy |=> busy;
   endproperty
   a_int_trig: assert property (p_int_trig) else $error("character did not start reading");

   property p_ext_only;
      @(posedge core_clk) disable iff (!rst_n)
      ctrl_q.ext_mode && !foot_rise && st_q == srr_pkg::TX_IDLE |=> !busy;
   endproperty
   a_ext_only: assert property (p_ext_only) else $error("reading without closure");

   property p_mode_default;
      @(posedge core_clk) disable iff (!rst_n)
      !ctrl_wr_seen_q |-> !ctrl_q.ext_mode;
   endproperty
   a_mode_default: assert property (p_mode_default) else $error("trigger not internal");

   property p_five_chars;
      @(posedge core_clk) disable iff (!rst_n)
      s_char_end |-> (char_q <= srr_pkg::LAST_CHAR);
   endproperty
   a_five_chars: assert property (p_five_chars) else $error("more than five characters");

   property p_idle_after;
      @(posedge core_clk) disable iff (!rst_n)
      s_last_end |=> !busy && tx_line;
   endproperty
   a_idle_after: assert property (p_idle_after) else $error("no idle after fifth digit");

   property p_ascii;
      @(posedge core_clk) disable iff (!rst_n)
      st_q == srr_pkg::TX_LOAD |=> shf_q == srr_pkg::ASCII_ZERO + {4'h0, $past(cur_digit)};
   endproperty
   a_ascii: assert property (p_ascii) else $error("character not ascii digit");

endmodule

// file: rtl/srr_pkg.sv
// constants, types and baud table shared by the serial reading responder
package srr_pkg;

   // ----------------------------------------------------------------
   // clock, widths and defaults
   // ----------------------------------------------------------------
   localparam longint      CLK_HZ     = 125_000_000;
   localparam int          DIV_W      = 22;
   localparam int          NDIG       = 5;
   localparam int          CODE_W     = 4;
   localparam int          ADDR_W     = 4;
   localparam int          DATA_W     = 32;
   localparam int          CNT_W      = 8;
   localparam logic [3:0]  BAUD_DEF   = 4'he;
   localparam logic [7:0]  ASCII_ZERO = 8'h30;
   localparam logic [2:0]  LAST_BIT7  = 3'h6;
   localparam logic [2:0]  LAST_BIT8  = 3'h7;
   localparam logic [2:0]  LAST_CHAR  = 3'h4;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [3:0]  A_CTRL     = 4'h0;
   localparam logic [3:0]  A_STAT     = 4'h1;
   localparam logic [3:0]  A_READ     = 4'h2;

   typedef struct packed {
      logic                ext_mode;
      logic                word8;
      logic [3:0]          baud_code;
   } srr_ctrl_t;

   localparam srr_ctrl_t   CTRL_RST   = '{ext_mode: 1'b0, word8: 1'b0, baud_code: BAUD_DEF};

   typedef struct packed {
      logic [7:0]          readings;
      logic                foot;
      logic                rx_level;
      logic                busy;
   } srr_stat_t;

   typedef logic [NDIG-1:0][3:0] srr_digits_t;

   typedef enum logic [2:0] {TX_IDLE, TX_LOAD, TX_START, TX_DATA, TX_STOP} srr_tx_st_t;

   // ----------------------------------------------------------------
   // baud table, rates in hundredths of a baud
   // ----------------------------------------------------------------
   localparam longint RATE_X100 [16] = '{
      5000, 7500, 11000, 13450, 15000, 30000, 60000, 120000,
      180000, 200000, 240000, 360000, 480000, 720000, 960000, 1920000};

   // clock rate is an argument so that a scaled clock keeps the same table
   function automatic logic [DIV_W-1:0] baud_div(input logic [3:0] code, input longint clk_hz);
      baud_div = DIV_W'((clk_hz * 100) / RATE_X100[code]);
   endfunction

endpackage

// file: rtl/srr_rx.sv
// receive side: reports each complete serial character as a pulse
`timescale 1ns/100ps
module srr_rx
(
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     rx_line,
   input  wire logic [srr_pkg::DIV_W-1:0] div,
   input  wire logic                     word8,
   output logic                          done
);

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} srr_rx_st_t;

   srr_rx_st_t                  st_q;
   logic [srr_pkg::DIV_W-1:0]   cnt_q;
   logic [2:0]                  bit_q;
   logic                        tick;
   logic [2:0]                  last_bit;

   assign tick     = (cnt_q == '0);
   assign last_bit = word8 ? srr_pkg::LAST_BIT8 : srr_pkg::LAST_BIT7;

   // value of the character is never used, any byte counts
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q  <= RX_IDLE;
         cnt_q <= '0;
         bit_q <= '0;
         done  <= 1'b0;
      end
      else
      begin
         done  <= 1'b0;
         cnt_q <= tick ? div - 1'b1 : cnt_q - 1'b1;
         unique case (st_q)
            RX_IDLE:
            begin
               cnt_q <= div >> 1;
               if (!rx_line)
                  st_q <= RX_START;
            end
            RX_START:
               if (tick)
               begin
                  st_q  <= rx_line ? RX_IDLE : RX_BITS;
                  bit_q <= '0;
               end
            RX_BITS:
               if (tick)
               begin
                  bit_q <= bit_q + 1'b1;
                  if (bit_q == last_bit)
                     st_q <= RX_STOP;
               end
            RX_STOP:
               if (tick)
               begin
                  st_q <= RX_IDLE;
                  done <= 1'b1;
               end
         endcase
      end
   end

endmodule

// file: bench/srr_host.sv
// host serial port model: sends request characters and collects the readings
`timescale 1ns/100ps
module srr_host
(
   input  wire logic                      clk,
   input  wire logic [srr_pkg::DIV_W-1:0] div,
   input  wire logic                      word8,
   input  wire logic                      from_dev,
   output logic                           to_dev
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] got [$];
   int         frame_err;
   int         i;
   logic [7:0] b;

   initial
   begin
      to_dev = 1'b1;
      frame_err = 0;
   end

   // ----------------------------------------------------------------
   // request character, one start bit, no parity, one stop bit
   // ----------------------------------------------------------------
   // one frame per wanted reading, data line only
   task automatic send_char(input logic [7:0] c);
      int k;
      @(posedge clk);
      to_dev <= 1'b0;
      repeat (div) @(posedge clk);
      for (k = 0; k < (word8 ? 8 : 7); k++)
      begin
         to_dev <= c[k];
         repeat (div) @(posedge clk);
      end
      to_dev <= 1'b1;
      repeat (div) @(posedge clk);
   endtask

   // ----------------------------------------------------------------
   // receiver, samples each bit in its middle
   // ----------------------------------------------------------------
   // a parity bit would land on the stop position and count as an error
   initial
   begin
      forever
      begin
         // falling edge: the line is settled, never caught mid-update
         @(negedge clk);
         if (from_dev === 1'b0)
         begin
            repeat (div >> 1) @(negedge clk);
            if (from_dev !== 1'b0)
               frame_err++;
            b = 8'h00;
            for (i = 0; i < (word8 ? 8 : 7); i++)
            begin
               repeat (div) @(negedge clk);
               b[i] = from_dev;
            end
            repeat (div) @(negedge clk);
            if (from_dev !== 1'b1)
               frame_err++;
            got.push_back(b);
         end
      end
   end
endmodule

// file: bench/srr_top_test.sv
// self-checking bench for the serial reading responder
`timescale 1ns/100ps
module srr_top_test;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   // fastest code and a scaled clock rate give 100-clock bits and a short run
   localparam longint SIM_HZ  = 1_920_000;
   localparam int     BIT_CYC = int'(SIM_HZ / 19200);

   logic                          core_clk;
   logic                          rst_b;
   logic                          rx_line;
   logic                          tx_line;
   logic                          foot_closed;
   srr_pkg::srr_digits_t          digits;
   logic [srr_pkg::ADDR_W-1:0]    reg_addr;
   logic [srr_pkg::DATA_W-1:0]    reg_wdata;
   logic                          reg_wr;
   logic                          reg_rd;
   logic [srr_pkg::DATA_W-1:0]    reg_rdata;
   logic                          busy;
   logic                          host_word8;
   int                            bad_count;
   int                            checked;

   srr_top #(.CLK_HZ(SIM_HZ)) srr_top_i (.core_clk(core_clk), .rst_b(rst_b), .rx_line(rx_line), .tx_line(tx_line),
      .foot_closed(foot_closed), .digits(digits), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy));

   srr_host srr_host_i (.clk(core_clk), .div(srr_pkg::DIV_W'(BIT_CYC)), .word8(host_word8),
      .from_dev(tx_line), .to_dev(rx_line));

   always #4 core_clk = ~core_clk;

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic complete_run;
      $display("checks %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic wait_busy(input logic lvl, input int bound);
      int n;
      n = 0;
      while (busy !== lvl && n < bound)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (busy !== lvl)
      begin
         check_val(32'(busy), 32'(lvl), "busy wait ran out");
         complete_run();
      end
   endtask

   // counts cycles with busy high or a start bit on the line
   task automatic idle_check(input int cycles, input string what);
      int n;
      n = 0;
      repeat (cycles)
      begin
         @(posedge core_clk);
         #1;
         if (busy !== 1'b0 || tx_line !== 1'b1)
            n++;
      end
      check_val(32'(n), 32'h0, what);
   endtask

   task automatic check_reading(input logic [7:0] e [5]);
      int k;
      check_val(32'(srr_host_i.got.size()), 32'h5, "characters per reading");
      for (k = 0; k < 5 && srr_host_i.got.size() > 0; k++)
         check_val(32'(srr_host_i.got.pop_front()), 32'(e[k]), "reading character");
      srr_host_i.got.delete();
      check_val(32'(srr_host_i.frame_err), 32'h0, "frame errors");
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic reset_regs;
      logic [31:0] d;
      reg_read(srr_pkg::A_CTRL, d);
      check_val(d, 32'h0000000e, "ctrl after reset");
      reg_read(srr_pkg::A_STAT, d);
      check_val(d, 32'h00000002, "status after reset");
      check_val(32'(tx_line), 32'h1, "tx idle level");
      reg_write(srr_pkg::A_STAT, 32'hffffffff);
      reg_read(srr_pkg::A_STAT, d);
      check_val(d, 32'h00000002, "status is read only");
      reg_write(4'h9, 32'hffffffff);
      reg_read(4'h9, d);
      check_val(d, 32'h00000000, "unmapped address");
   endtask

   task automatic internal_trigger;
      logic [31:0] d;
      reg_write(srr_pkg::A_CTRL, 32'h0000000f);
      @(posedge core_clk);
      host_word8 <= 1'b0;
      digits <= {4'h9, 4'h0, 4'h7, 4'h4, 4'h2};
      foot_closed <= 1'b1;
      srr_host_i.send_char(8'h41);
      wait_busy(1'b1, 2 * BIT_CYC);
      @(posedge core_clk);
      digits <= 20'h11111;
      foot_closed <= 1'b0;
      srr_host_i.send_char(8'h00);
      wait_busy(1'b0, 60 * BIT_CYC);
      idle_check(20 * BIT_CYC, "extra reading");
      check_reading('{8'h39, 8'h30, 8'h37, 8'h34, 8'h32});
      reg_read(srr_pkg::A_STAT, d);
      check_val(d, 32'h0000000a, "one reading counted");
   endtask

   task automatic external_trigger;
      logic [31:0] d;
      reg_write(srr_pkg::A_CTRL, 32'h0000003f);
      @(posedge core_clk);
      host_word8 <= 1'b1;
      digits <= {4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
      srr_host_i.send_char(8'hc5);
      idle_check(4 * BIT_CYC, "serial request in external mode");
      @(posedge core_clk);
      foot_closed <= 1'b1;
      wait_busy(1'b1, 4);
      wait_busy(1'b0, 60 * BIT_CYC);
      @(posedge core_clk);
      foot_closed <= 1'b0;
      idle_check(2 * BIT_CYC, "closure held gives one reading");
      check_reading('{8'h31, 8'h32, 8'h33, 8'h34, 8'h38});
      reg_read(srr_pkg::A_STAT, d);
      check_val(d, 32'h00000012, "two readings counted");
      reg_read(srr_pkg::A_READ, d);
      check_val(d, 32'h00012348, "digits held for reading");
      reg_read(srr_pkg::A_CTRL, d);
      check_val(d, 32'h0000003f, "ctrl read back");
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      rst_b = 1'b0;
      foot_closed = 1'b0;
      digits = '0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      host_word8 = 1'b0;
      bad_count = 0;
      checked = 0;
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
      reset_regs();
      internal_trigger();
      external_trigger();
      complete_run();
   end
endmodule
